// [fdc_console.sv]
// module: front panel run control, stepping, breakpoint and substitution logic
//
// The APB interface to the registers and the address map were decided locally.
module fdc_console
   import fdc_pkg::*;
#(
   parameter int DEBOUNCE_CYC = fdc_pkg::DEBOUNCE_CYC_DEF
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // processor bus, sampled
   input wire fdc_pkg::fdc_bus_t bus_in,
   // processor bus, driven
   output logic ready_console_n,
   output logic ready_o,
   output logic ready_oe_n,
   output logic override_n,
   output logic [7:0] mdata_o,
   output logic [7:0] mdata_oe_n,
   output logic scope_sync,
   // operator keys and switches
   input wire logic [fdc_pkg::NUM_KEYS-1:0] keys,
   input wire logic [7:0] data_keys,
   input wire logic [13:0] bp_addr_sw,
   input wire logic bp_stop_link,
   input wire logic sub_sw,
   input wire logic auto_sub_sw,
   input wire logic powerup_sw,
   // lamps
   output fdc_pkg::fdc_lamps_t lamps
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   localparam int DB_W = $clog2(DEBOUNCE_CYC + 1);
   localparam int DW_W = $clog2(DATA_WINDOW_MAX_CYC + 2);

   fdc_bus_t bus_meta;
   fdc_bus_t bus_sync;
   fdc_bus_t bus_q;
   logic [NUM_KEYS+25:0] sw_meta;
   logic [NUM_KEYS+25:0] sw_sync;
   logic [NUM_KEYS-1:0] key_level;
   logic [NUM_KEYS-1:0] key_stable;
   logic [DB_W-1:0] db_cnt [NUM_KEYS];
   logic [NUM_KEYS-1:0] key_ev;
   logic [NUM_KEYS-1:0] soft_ev;
   logic [NUM_KEYS-1:0] press;
   logic [7:0] data_keys_s;
   logic [13:0] bp_addr_s;
   logic bp_stop_s;
   logic sub_s;
   logic auto_sub_s;
   logic pwr_s;
   fdc_mode_t mode;
   fdc_mode_t next_mode;
   logic hold;
   logic next_hold;
   logic whole;
   logic trap_en;
   logic [1:0] pu_cnt;
   logic pu_armed;
   logic [31:0] config_reg;
   logic late_flag;
   logic seq_flag;
   logic [DW_W-1:0] dw_cnt;
   logic dw_run;
   logic page_or_wait_seen;
   logic [13:0] addr_cap;
   logic [1:0] kind_cap;
   logic [7:0] data_cap;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // converts an active-low bus field to positive logic
   function automatic logic [13:0] lowtrue(input logic [13:0] v);
      lowtrue = ~v;
   endfunction : lowtrue

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   // two stages for every bus, key and switch pin (apb pins are not synchronised), a third bus stage for edge detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bus_meta <= '1;
         bus_sync <= '1;
         bus_q <= '1;
         sw_meta <= '0;
         sw_sync <= '0;
      end
      else
      begin
         bus_meta <= bus_in;
         bus_sync <= bus_meta;
         bus_q <= bus_sync;
         sw_meta <= {keys, data_keys, bp_addr_sw, bp_stop_link, sub_sw, auto_sub_sw, powerup_sw};
         sw_sync <= sw_meta;
      end
   end

   assign {key_level, data_keys_s, bp_addr_s, bp_stop_s, sub_s, auto_sub_s, pwr_s} = sw_sync;

   // ----------------------------------------------------------------
   // key debounce
   // ----------------------------------------------------------------
   // a level must hold for the whole debounce time to be accepted
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         key_stable <= '0;
         key_ev <= '0;
         for (int i = 0; i < NUM_KEYS; i++)
            db_cnt[i] <= '0;
      end
      else
      begin
         for (int i = 0; i < NUM_KEYS; i++)
         begin
            key_ev[i] <= 1'b0;
            if (key_level[i] == key_stable[i])
               db_cnt[i] <= '0;
            else if (db_cnt[i] == DB_W'(DEBOUNCE_CYC))
            begin
               db_cnt[i] <= '0;
               key_stable[i] <= key_level[i];
               key_ev[i] <= key_level[i]; // one pulse per press
            end
            else
               db_cnt[i] <= db_cnt[i] + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // positive-logic views of the active-low bus lines
   wire console_on = config_reg[CONFIG_ON];
   wire t2_now = !bus_sync.page_address_state_n;
   wire t2_rise = t2_now && bus_q.page_address_state_n;
   wire t2_fall = !t2_now && !bus_q.page_address_state_n;
   wire t3_now = !bus_sync.post_address_state_n;
   wire t3_rise = t3_now && bus_q.post_address_state_n;
   wire wait_now = !bus_sync.wait_n;
   wire stop_now = !bus_sync.stop_n;
   wire [13:0] addr_now = lowtrue(bus_sync.addr_n);
   wire [1:0] kind_now = {bus_sync.cycle_kind_bit_hi, !bus_sync.cycle_kind_bit_lo_n};
   wire is_fetch = (kind_now == KIND_FETCH);
   wire auto_sub = console_on && auto_sub_s;
   wire sub_on = console_on && (sub_s || auto_sub_s);

   // qualified breakpoint match, fetch cycles only
   wire bp_hit = console_on && trap_en && t2_rise && is_fetch && (addr_now == bp_addr_s);
   // a cycle that the selected stepping option stops at
   wire step_stop = t2_rise && (!whole || is_fetch);

   assign soft_ev = (psel && penable && pwrite && paddr == REG_CTRL) ? pwdata[NUM_KEYS-1:0] : '0;
   assign press = key_ev | soft_ev;

   // ----------------------------------------------------------------
   // run mode and hold
   // ----------------------------------------------------------------
   // mode latch and console hold of the ready line
   always_comb
   begin
      next_mode = mode;
      next_hold = hold;
      case (mode)
         MODE_FREE:
         begin
            next_hold = 1'b0; // runs freely
            if (press[KEY_STEP])
               next_mode = MODE_STEP;
         end
         MODE_STEP:
         begin
            if (press[KEY_FREE])
            begin
               next_mode = MODE_FREE; // resume until next match
               next_hold = 1'b0;
            end
            else if (press[KEY_STEP] && hold)
               next_hold = 1'b0; // one step released
            else if (step_stop)
               next_hold = 1'b1;
         end
         default:
         begin
            next_mode = MODE_FREE;
            next_hold = 1'b0;
         end
      endcase
      if (bp_hit && bp_stop_s)
      begin
         next_mode = MODE_STEP;
         next_hold = 1'b1;
      end
      if (pu_armed && t2_rise)
      begin
         next_mode = MODE_STEP; // first cycle held
         next_hold = 1'b1;
      end
      if (!console_on || auto_sub)
         next_hold = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode <= MODE_FREE;
         hold <= 1'b0;
         whole <= 1'b1;
         trap_en <= 1'b0;
      end
      else
      begin
         mode <= next_mode;
         hold <= next_hold;
         if (press[KEY_INS])
            whole <= 1'b1;
         else if (press[KEY_CYCLE])
            whole <= 1'b0;
         if (press[KEY_TRAP])
            trap_en <= !trap_en;
      end
   end

   // power-up option caught once the switch synchroniser has settled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pu_cnt <= '0;
         pu_armed <= 1'b0;
      end
      else if (pu_cnt != 2'(PU_SETTLE_CYC))
      begin
         pu_cnt <= pu_cnt + 1'b1;
         if (pu_cnt == 2'(PU_SETTLE_CYC - 1))
            pu_armed <= pwr_s && console_on;
      end
      else if (t2_rise)
         pu_armed <= 1'b0;
   end

   // ----------------------------------------------------------------
   // bus drivers
   // ----------------------------------------------------------------
   // registered drive of hold, ready, override, keyed data and scope sync
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ready_console_n <= 1'b1;
         ready_oe_n <= 1'b1;
         override_n <= 1'b1;
         mdata_o <= '0;
         mdata_oe_n <= '1;
         scope_sync <= 1'b0;
      end
      else
      begin
         ready_console_n <= !next_hold; // low forces wait
         ready_oe_n <= !auto_sub; // ready held active, no wait
         override_n <= !sub_on; // cards silenced
         mdata_o <= ~data_keys_s; // keys in place of memory
         mdata_oe_n <= sub_on ? 8'h00 : 8'hFF;
         scope_sync <= bp_hit; // pulse with or without stop
      end
   end

   assign ready_o = 1'b0;

   // ----------------------------------------------------------------
   // cycle capture and timing monitor
   // ----------------------------------------------------------------
   // address and kind latched at page state, input data during window
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         addr_cap <= '0;
         kind_cap <= '0;
         data_cap <= '0;
      end
      else
      begin
         if (t2_now)
         begin
            addr_cap <= addr_now;
            kind_cap <= kind_now;
         end
         if (bus_sync.data_window)
            data_cap <= ~bus_sync.mdata_n;
      end
   end

   // window start deadline and post-address order checks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dw_cnt <= '0;
         dw_run <= 1'b0;
         late_flag <= 1'b0;
         seq_flag <= 1'b0;
         page_or_wait_seen <= 1'b1; // a post state cut by reset is no order error
      end
      else
      begin
         if (t2_fall)
         begin
            dw_run <= !bus_sync.data_window;
            dw_cnt <= '0;
         end
         else if (bus_sync.data_window)
            dw_run <= 1'b0;
         else if (dw_run)
            dw_cnt <= dw_cnt + 1'b1;
         if (t2_now || wait_now)
            page_or_wait_seen <= 1'b1;
         else if (t3_rise)
            page_or_wait_seen <= 1'b0;
         // sticky flags; a new event beats a clear in the same cycle
         if ((dw_run && dw_cnt >= DW_W'(DATA_WINDOW_MAX_CYC)) ||
             (t3_now && !bus_sync.data_window))
            late_flag <= 1'b1;
         else if (psel && penable && pwrite && paddr == REG_STATUS && pwdata[ST_LATE])
            late_flag <= 1'b0;
         if (t3_rise && !page_or_wait_seen)
            seq_flag <= 1'b1;
         else if (psel && penable && pwrite && paddr == REG_STATUS && pwdata[ST_SEQ])
            seq_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // lamps
   // ----------------------------------------------------------------
   // i/o class from the two top shown bits, then group or port
   wire [5:0] page_cap = addr_cap[13:8];
   wire io_cycle = (kind_cap == KIND_IO);
   wire io_in = io_cycle && (page_cap[5:4] == IO_INPUT_CLASS);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lamps <= '0;
      else
      begin
         lamps.run <= (mode == MODE_FREE) && !wait_now && !stop_now; // dark while stepping
         lamps.wait_lamp <= wait_now;
         lamps.stop <= stop_now;
         lamps.step <= (mode == MODE_STEP);
         lamps.whole <= whole;
         lamps.trap <= trap_en;
         lamps.kind <= 4'h1 << kind_cap;
         lamps.addr_lo <= addr_cap[7:0]; // input address or output data
         lamps.page <= page_cap;
         lamps.inputs <= data_cap;
         lamps.io_input <= io_in;
         lamps.io_group <= io_in ? page_cap[3:1] : 3'h0;
         lamps.io_port <= (io_cycle && !io_in) ? page_cap[4:0] : 5'h00;
      end
   end

   // ----------------------------------------------------------------
   // apb registers
   // ----------------------------------------------------------------
   // config write; zero wait states, unmapped addresses answer with an error
   wire wr_access = psel && penable && pwrite;
   wire hit_ctrl = (paddr == REG_CTRL);
   wire hit_config = (paddr == REG_CONFIG);
   wire hit_status = (paddr == REG_STATUS);
   wire hit_addr = (paddr == REG_ADDR);
   wire hit_data = (paddr == REG_DATA);
   wire mapped = hit_ctrl || hit_config || hit_status || hit_addr || hit_data;
   wire [31:0] status_word = {22'h0, seq_flag, late_flag, kind_cap, stop_now, wait_now, hold,
                              trap_en, whole, mode == MODE_STEP};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         config_reg <= CONFIG_RESET;
      else if (wr_access && hit_config)
         config_reg <= {31'h0, pwdata[CONFIG_ON]};
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always_comb
   begin
      if (!psel || pwrite)
         prdata = 32'h00000000;
      else if (hit_config)
         prdata = config_reg;
      else if (hit_status)
         prdata = status_word;
      else if (hit_addr)
         prdata = {18'h0, addr_cap};
      else if (hit_data)
         prdata = {24'h0, data_cap};
      else
         prdata = 32'h00000000;
   end

endmodule : fdc_console

// [fdc_pkg.sv]
// package: constants, encodings and carriers for the front panel debug control
package fdc_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int DATA_WINDOW_MAX_NS = 500;
   localparam int DATA_WINDOW_MAX_CYC = (DATA_WINDOW_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
      DATA_WINDOW_MAX_NS / CLK_PERIOD_NS;
   localparam int DEBOUNCE_US = 5000;
   localparam int DEBOUNCE_CYC_DEF = DEBOUNCE_US * 1000 / CLK_PERIOD_NS;
   localparam int PU_SETTLE_CYC = 3;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CONFIG = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_ADDR = 8'h0C;
   localparam logic [7:0] REG_DATA = 8'h10;
   localparam logic [31:0] CONFIG_RESET = 32'h00000001;

   // ctrl bits: write one to press a soft key
   localparam int CTRL_FREE = 0;
   localparam int CTRL_STEP = 1;
   localparam int CTRL_INS = 2;
   localparam int CTRL_CYCLE = 3;
   localparam int CTRL_TRAP = 4;
   // config bits
   localparam int CONFIG_ON = 0;
   // status bits; the two sticky error flags clear by write one
   localparam int ST_MODE = 0;
   localparam int ST_WHOLE = 1;
   localparam int ST_TRAP = 2;
   localparam int ST_HOLD = 3;
   localparam int ST_WAIT = 4;
   localparam int ST_STOP = 5;
   localparam int ST_KIND = 6;
   localparam int ST_LATE = 8;
   localparam int ST_SEQ = 9;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   localparam int NUM_KEYS = 5;
   localparam int KEY_FREE = 0;
   localparam int KEY_STEP = 1;
   localparam int KEY_INS = 2;
   localparam int KEY_CYCLE = 3;
   localparam int KEY_TRAP = 4;
   localparam logic [1:0] IO_INPUT_CLASS = 2'h0;

   typedef enum logic [1:0] {
      KIND_FETCH = 2'b00,
      KIND_READ = 2'b01,
      KIND_IO = 2'b10,
      KIND_WRITE = 2'b11
   } fdc_kind_t;

   typedef enum logic {
      MODE_FREE = 1'b0,
      MODE_STEP = 1'b1
   } fdc_mode_t;

   // ----------------------------------------------------------------
   // carriers; names ending in _n are active low bus lines
   // ----------------------------------------------------------------
   typedef struct packed {
      logic page_address_state_n;
      logic post_address_state_n;
      logic data_window;
      logic cycle_kind_bit_lo_n;
      logic cycle_kind_bit_hi;
      logic wait_n;
      logic stop_n;
      logic [13:0] addr_n;
      logic [7:0] mdata_n;
   } fdc_bus_t;

   typedef struct packed {
      logic run;
      logic wait_lamp;
      logic stop;
      logic step;
      logic whole;
      logic trap;
      logic [3:0] kind;
      logic [7:0] addr_lo;
      logic [5:0] page;
      logic [7:0] inputs;
      logic io_input;
      logic [2:0] io_group;
      logic [4:0] io_port;
   } fdc_lamps_t;

endpackage : fdc_pkg

// [fdc_checker.sv]
// checker: concurrent assertions on the console ports
module fdc_checker
   import fdc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   // processor side and lamps
   input wire logic ready_console_n,
   input wire logic ready_oe_n,
   input wire logic override_n,
   input wire logic [7:0] mdata_oe_n,
   input wire logic scope_sync,
   input wire fdc_pkg::fdc_lamps_t lamps
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   sequence s_held; !ready_console_n && lamps.step; endsequence
   sequence s_step_wr; psel && penable && pwrite && paddr == REG_CTRL && pwdata[CTRL_STEP]; endsequence
   property p_step_release; s_held ##0 s_step_wr |=> ready_console_n; endproperty
   property p_sync_one; scope_sync |=> !scope_sync; endproperty
   property p_sync_trap; scope_sync |-> lamps.trap; endproperty
   property p_sub_drive; !override_n |-> mdata_oe_n == 8'h00; endproperty
   property p_auto_ready; !ready_oe_n [*3] |-> ready_console_n; endproperty
   property p_one_mode; !(lamps.run && lamps.step); endproperty
   property p_io_in; lamps.kind[2] |-> lamps.io_input == (lamps.page[5:4] == 2'b00); endproperty
   property p_io_grp; lamps.kind[2] && lamps.io_input |-> lamps.io_group == lamps.page[3:1]; endproperty
   property p_io_out; lamps.kind[2] && !lamps.io_input |-> lamps.io_port == lamps.page[4:0]; endproperty
   property p_kind; $onehot0(lamps.kind); endproperty
   a_step_release: assert property (p_step_release) else $error("step not released");
   a_sync_one: assert property (p_sync_one) else $error("sync too wide");
   a_sync_trap: assert property (p_sync_trap) else $error("sync without trap");
   a_sub_drive: assert property (p_sub_drive) else $error("keys not driven");
   a_auto_ready: assert property (p_auto_ready) else $error("hold during auto");
   a_one_mode: assert property (p_one_mode) else $error("two modes lit");
   a_io_in: assert property (p_io_in) else $error("io class wrong");
   a_io_grp: assert property (p_io_grp) else $error("io group wrong");
   a_io_out: assert property (p_io_out) else $error("io port wrong");
   a_kind: assert property (p_kind) else $error("kind not one hot");
endmodule : fdc_checker

bind fdc_console fdc_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .ready_console_n, .ready_oe_n, .override_n, .mdata_oe_n, .scope_sync, .lamps);

// [fdc_proc_model.sv]
// model: processor bus cycles and memory card seen by the console
module fdc_proc_model
   import fdc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // console drives
   input wire logic ready_console_n,
   input wire logic [7:0] mdata_o,
   input wire logic [7:0] mdata_oe_n,
   // cycle program from the bench
   input wire fdc_pkg::fdc_kind_t kind,
   input wire logic [13:0] addr,
   // processor pins and counts
   output fdc_pkg::fdc_bus_t bus,
   output int fetches,
   output int waits,
   output logic [7:0] last_data
);
   localparam logic [7:0] MEM_DATA = 8'hC3;
   fdc_bus_t b;
   fdc_kind_t k;
   logic [7:0] md_n;
   // memory card answers at once unless the console overrides it
   assign md_n = (mdata_oe_n == 8'h00) ? mdata_o : ~MEM_DATA;
   assign bus = {b[28:8], md_n};
   // one bus cycle: idle, page state, optional wait, post state
   initial
   begin
      b = '1;
      b.data_window = 1'b0;
      fetches = 0;
      waits = 0;
      last_data = '0;
      forever
      begin
         repeat (2) @(posedge pclk);
         k = kind;
         b.addr_n <= ~addr;
         b.cycle_kind_bit_hi <= k[1];
         b.cycle_kind_bit_lo_n <= ~k[0];
         b.page_address_state_n <= 1'b0;
         repeat (6) @(posedge pclk);
         b.page_address_state_n <= 1'b0 ^ 1'b1;
         b.data_window <= 1'b1;
         if (ready_console_n === 1'b0)
         begin
            waits++;
            b.wait_n <= 1'b0;
            while (ready_console_n !== 1'b1) @(posedge pclk);
            b.wait_n <= 1'b1;
         end
         b.post_address_state_n <= 1'b0;
         repeat (3) @(posedge pclk);
         last_data = ~bus.mdata_n;
         fetches += (k == KIND_FETCH);
         b.post_address_state_n <= 1'b1;
         b.data_window <= 1'b0;
         b.addr_n <= addr; // released lines show the inverse
      end
   end
endmodule : fdc_proc_model

// [tb.sv]
// testbench: front panel console against a processor bus model
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("Error: %s exp %0h got %0h", n, e, g); end end
module tb
   import fdc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [7:0] a; logic [31:0] e; logic [31:0] m; logic err;} fdc_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, scope_sync, er;
   logic bp_stop_link, sub_sw, auto_sub_sw, powerup_sw, ready_console_n, ready_o, ready_oe_n, override_n;
   logic [7:0] paddr, mdata_o, mdata_oe_n, data_keys, last_data;
   logic [31:0] pwdata, prdata, rd;
   logic [13:0] bp_addr_sw, addr;
   logic [NUM_KEYS-1:0] keys;
   fdc_bus_t bus_in;
   fdc_lamps_t lamps;
   fdc_kind_t kind;
   int mismatches = 0, check_count = 0, fetches, waits, sync_cnt = 0, f0, w0, s0;
   fdc_row_t rows [4] = '{'{REG_CTRL, 32'h0, '1, 1'b0}, '{REG_CONFIG, 32'h1, '1, 1'b0},
      '{REG_STATUS, 32'h2, 32'h7, 1'b0}, '{8'h14, 32'h0, '1, 1'b1}};
   fdc_console #(.DEBOUNCE_CYC(4)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .bus_in, .ready_console_n, .ready_o, .ready_oe_n, .override_n, .mdata_o, .mdata_oe_n,
      .scope_sync, .keys, .data_keys, .bp_addr_sw, .bp_stop_link, .sub_sw, .auto_sub_sw, .powerup_sw, .lamps);
   fdc_proc_model model_u (.pclk, .presetn, .ready_console_n, .mdata_o, .mdata_oe_n, .kind, .addr,
      .bus(bus_in), .fetches, .waits, .last_data);
   // clock and sync pulse counter
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) if (scope_sync === 1'b1) sync_cnt++;
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic ctrl(input int b);
      apb(1'b1, REG_CTRL, 32'h1 << b);
   endtask : ctrl
   task automatic press(input int k);
      @(posedge pclk) keys[k] <= 1'b1;
      repeat (12) @(posedge pclk);
      keys[k] <= 1'b0;
      repeat (12) @(posedge pclk);
   endtask : press
   task automatic run(input int n);
      repeat (n) @(posedge pclk);
   endtask : run
   task automatic done(input string n);
      $display("test %s finished", n);
   endtask : done
   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   // watchdog
   initial
   begin
      run(30000);
      mismatches++;
      print_verdict();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, keys} = '0;
      {sub_sw, auto_sub_sw, powerup_sw, bp_stop_link, bp_addr_sw} = 18'h04000;
      data_keys = 8'h5A;
      kind = KIND_FETCH;
      addr = 14'h0123;
      run(20);
      `CHK("hold_rst", 1'b1, ready_console_n)
      `CHK("oe_rst", 8'hFF, mdata_oe_n)
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         apb(1'b0, rows[i].a, 32'h0);
         `CHK("reg", rows[i].e, rd & rows[i].m)
         `CHK("slverr", rows[i].err, er)
      end
      done("regs");
      f0 = fetches;
      w0 = waits;
      run(80);
      `CHK("free_run", 1'b1, fetches > f0 + 4)
      `CHK("free_wait", w0, waits)
      `CHK("addr_lo", 8'h23, lamps.addr_lo)
      `CHK("page", 6'h01, lamps.page)
      `CHK("kind", 4'h1, lamps.kind)
      `CHK("run_lamp", 1'b1, lamps.run)
      done("free");
      press(KEY_STEP);
      run(40);
      `CHK("step_lamp", 1'b1, lamps.step)
      `CHK("fetch_hold", 1'b0, ready_console_n)
      `CHK("wait_lamp", 1'b1, lamps.wait_lamp)
      f0 = fetches;
      ctrl(CTRL_STEP);
      run(30);
      `CHK("one_step", f0 + 1, fetches)
      `CHK("rehold", 1'b0, ready_console_n)
      press(KEY_STEP);
      run(30);
      `CHK("key_step", f0 + 2, fetches)
      done("step");
      @(posedge pclk) kind <= KIND_READ;
      ctrl(CTRL_STEP);
      w0 = waits;
      run(60);
      `CHK("read_free", w0, waits)
      ctrl(CTRL_CYCLE);
      run(30);
      `CHK("cyc_hold", 1'b0, ready_console_n)
      `CHK("read_kind", 4'h2, lamps.kind)
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK("mode", 2'b01, rd[1:0])
      `CHK("order_flags", 2'b00, rd[9:8])
      done("cycle");
      @(posedge pclk);
      kind <= KIND_IO;
      addr <= 14'h0AB5;
      ctrl(CTRL_STEP);
      run(30);
      `CHK("io_in", 1'b1, lamps.io_input)
      `CHK("io_grp", 3'h5, lamps.io_group)
      `CHK("in_addr", 8'hB5, lamps.addr_lo)
      @(posedge pclk) addr <= 14'h1E3C;
      ctrl(CTRL_STEP);
      run(30);
      `CHK("io_out", 1'b0, lamps.io_input)
      `CHK("io_port", 5'h1E, lamps.io_port)
      `CHK("out_data", 8'h3C, lamps.addr_lo)
      done("io");
      @(posedge pclk);
      kind <= KIND_READ;
      {addr, bp_addr_sw} <= {14'h0123, 14'h0123};
      ctrl(CTRL_TRAP);
      ctrl(CTRL_FREE);
      s0 = sync_cnt;
      run(80);
      `CHK("read_nomatch", s0, sync_cnt)
      `CHK("read_run", 1'b1, ready_console_n)
      @(posedge pclk) kind <= KIND_FETCH;
      run(40);
      `CHK("bp_sync", s0 + 1, sync_cnt)
      `CHK("bp_hold", 1'b0, ready_console_n)
      `CHK("bp_step", 1'b1, lamps.step)
      ctrl(CTRL_FREE);
      run(40);
      `CHK("bp_again", s0 + 2, sync_cnt)
      `CHK("bp_rehold", 1'b0, ready_console_n)
      @(posedge pclk) bp_stop_link <= 1'b0;
      ctrl(CTRL_FREE);
      s0 = sync_cnt;
      run(60);
      `CHK("link_run", 1'b1, ready_console_n)
      `CHK("link_sync", 1'b1, sync_cnt > s0 + 2)
      ctrl(CTRL_TRAP);
      done("trap");
      @(posedge pclk) {bp_stop_link, sub_sw, data_keys} <= {2'b11, 8'hA6};
      run(40);
      `CHK("override", 1'b0, override_n)
      `CHK("sub_oe", 8'h00, mdata_oe_n)
      `CHK("sub_pol", 8'h59, mdata_o)
      `CHK("sub_data", 8'hA6, last_data)
      `CHK("inputs", 8'hA6, lamps.inputs)
      ctrl(CTRL_STEP);
      @(posedge pclk) auto_sub_sw <= 1'b1;
      run(30);
      w0 = waits;
      f0 = fetches;
      run(60);
      `CHK("auto_oe", 1'b0, ready_oe_n)
      `CHK("auto_wait", w0, waits)
      `CHK("auto_run", 1'b1, fetches > f0 + 3)
      `CHK("run_dark", 1'b0, lamps.run)
      done("subst");
      @(posedge pclk) {powerup_sw, sub_sw, auto_sub_sw, presetn} <= 4'h8;
      run(20);
      presetn <= 1'b1;
      run(25);
      f0 = fetches;
      run(40);
      `CHK("pu_step", 1'b1, lamps.step)
      `CHK("pu_hold", 1'b0, ready_console_n)
      `CHK("pu_fetch", f0, fetches)
      done("powerup");
      print_verdict();
   end
endmodule : tb
